// ---- hw/slcr_pkg.sv ----
// Shared constants, types and helpers for the serial link configuration registers.
// Assumes registers are word aligned on a 32-bit bus, with data in the low byte.
package slcr_pkg;

	// Register indices; the byte address is four times the index
	localparam logic [9:0] IDX_ENABLE = 10'h200;
	localparam logic [9:0] IDX_MODE   = 10'h201;
	localparam logic [9:0] IDX_KM1    = 10'h202;
	localparam logic [9:0] IDX_SWSYNC = 10'h203;
	localparam logic [9:0] IDX_CTRL   = 10'h204;

	// Values after reset
	localparam logic [7:0] RST_ENABLE = 8'h01;
	localparam logic [7:0] RST_MODE   = 8'h00;
	localparam logic [7:0] RST_KM1    = 8'h1F;
	localparam logic [7:0] RST_SWSYNC = 8'h01;
	localparam logic [7:0] RST_CTRL   = 8'h03;

	// Writable bits; reserved bits are not stored and read as zero
	localparam logic [7:0] MASK_ENABLE = 8'h01;
	localparam logic [7:0] MASK_MODE   = 8'h3F;
	localparam logic [7:0] MASK_KM1    = 8'hFF;
	localparam logic [7:0] MASK_SWSYNC = 8'h01;
	localparam logic [7:0] MASK_CTRL   = 8'h1F;

	// Field positions in the link control register
	localparam int CTRL_SCR_BIT   = 0;
	localparam int CTRL_FMT_BIT   = 1;
	localparam int CTRL_SEL_LSB   = 2;
	localparam int CTRL_UPPER_BIT = 4;

	// Lane and multiframe constants
	localparam int          LANE_COUNT      = 8;
	localparam int          UPPER_LANE_BASE = 4;
	localparam logic [15:0] K64_SCALE       = 16'h0100;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		SYNC_SEL_SE   = 2'h0,
		SYNC_SEL_TS   = 2'h1,
		SYNC_SEL_NONE = 2'h2,
		SYNC_SEL_RSVD = 2'h3
	} slcr_sync_sel_t;

	typedef struct packed {
		logic       en;
		logic [9:0] idx;
		logic [7:0] data;
	} slcr_wr_t;

	typedef struct packed {
		logic                  link_run;
		logic                  serdes_powerdown;
		logic [5:0]            mode;
		logic [15:0]           frames;
		logic [LANE_COUNT-1:0] lanes;
		logic                  twos_complement;
		logic                  scramble;
	} slcr_link_cfg_t;

	// Index decode, shared by the write and read paths
	function automatic logic slcr_idx_known(input logic [9:0] idx);
		return (idx >= IDX_ENABLE) && (idx <= IDX_CTRL);
	endfunction

	// Multiframe length for the block-coded modes
	function automatic logic [15:0] slcr_frames_64b(input logic [3:0] e, input logic [4:0] f);
		logic [15:0] num;
		num = K64_SCALE * {12'h000, e};
		if (f == 5'h00)
			return 16'h0000;
		return num / {11'h000, f};
	endfunction

endpackage

// ---- hw/slcr_axil_slave.sv ----
// AXI4-Lite slave front end: decodes word accesses into write pulses and read lookups.
// Assumes the register owner answers rd_word combinationally for rd_idx.
`timescale 1ns/1ps
module slcr_axil_slave #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// Write channels
	input  wire logic [ADDR_W-1:0] s_awaddr,
	input  wire logic              s_awvalid,
	output logic                   s_awready,
	input  wire logic [31:0]       s_wdata,
	input  wire logic [3:0]        s_wstrb,
	input  wire logic              s_wvalid,
	output logic                   s_wready,
	output logic [1:0]             s_bresp,
	output logic                   s_bvalid,
	input  wire logic              s_bready,
	// Read channels
	input  wire logic [ADDR_W-1:0] s_araddr,
	input  wire logic              s_arvalid,
	output logic                   s_arready,
	output logic [31:0]            s_rdata,
	output logic [1:0]             s_rresp,
	output logic                   s_rvalid,
	input  wire logic              s_rready,
	// Register side
	output slcr_pkg::slcr_wr_t     wr,
	output logic [9:0]             rd_idx,
	input  wire logic [7:0]        rd_word
);

	// Elaboration check: the index decode reads address bits 11:2
	if (ADDR_W < 12)
		$error("ADDR_W must be at least 12");

	logic              aw_held_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic              w_held_reg;
	logic [7:0]        wdata_reg;
	logic              wstrb0_reg;
	logic              do_write;
	logic              wr_known;
	logic              rd_known;

	// Address and data may arrive in either order; both are held until the write
	assign s_awready = !aw_held_reg && !s_bvalid;
	assign s_wready  = !w_held_reg && !s_bvalid;
	assign s_arready = !s_rvalid;
	assign do_write  = aw_held_reg && w_held_reg && !s_bvalid;
	assign wr_known  = slcr_pkg::slcr_idx_known(awaddr_reg[11:2]) && ((awaddr_reg >> 12) == '0);
	assign rd_known  = slcr_pkg::slcr_idx_known(s_araddr[11:2]) && ((s_araddr >> 12) == '0);
	assign rd_idx    = s_araddr[11:2];
	// Only byte lane 0 carries register bits
	assign wr.en     = do_write && wr_known && wstrb0_reg;
	assign wr.idx    = awaddr_reg[11:2];
	assign wr.data   = wdata_reg;

	// Write address holding
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_reg <= 1'b0;
			awaddr_reg  <= '0;
		end
		else if (s_awvalid && s_awready)
		begin
			aw_held_reg <= 1'b1;
			awaddr_reg  <= s_awaddr;
		end
		else if (do_write)
			aw_held_reg <= 1'b0;
	end

	// Write data holding
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held_reg <= 1'b0;
			wdata_reg  <= 8'h00;
			wstrb0_reg <= 1'b0;
		end
		else if (s_wvalid && s_wready)
		begin
			w_held_reg <= 1'b1;
			wdata_reg  <= s_wdata[7:0];
			wstrb0_reg <= s_wstrb[0];
		end
		else if (do_write)
			w_held_reg <= 1'b0;
	end

	// Write response; unmapped addresses get SLVERR
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_bvalid <= 1'b0;
			s_bresp  <= slcr_pkg::RESP_OKAY;
		end
		else if (do_write)
		begin
			s_bvalid <= 1'b1;
			s_bresp  <= wr_known ? slcr_pkg::RESP_OKAY : slcr_pkg::RESP_SLVERR;
		end
		else if (s_bready)
			s_bvalid <= 1'b0;
	end

	// Read data captured at the address handshake
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_rvalid <= 1'b0;
			s_rdata  <= 32'h00000000;
			s_rresp  <= slcr_pkg::RESP_OKAY;
		end
		else if (s_arvalid && s_arready)
		begin
			s_rvalid <= 1'b1;
			s_rdata  <= {24'h000000, rd_known ? rd_word : 8'h00};
			s_rresp  <= rd_known ? slcr_pkg::RESP_OKAY : slcr_pkg::RESP_SLVERR;
		end
		else if (s_rready)
			s_rvalid <= 1'b0;
	end

endmodule

// ---- hw/slcr_sync_select.sv ----
// Sync request source selection with pin synchronisers.
// Assumes both sync pins are active low and asynchronous to aclk.
`timescale 1ns/1ps
module slcr_sync_select (
	// Clock and reset
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	// Pins and controls
	input  wire logic                     se_pin_n,
	input  wire logic                     ts_pin_n,
	input  wire slcr_pkg::slcr_sync_sel_t sel,
	input  wire logic                     sw_req_n,
	// Request out
	output logic                          sync_request
);

	logic [1:0] se_sync_reg;
	logic [1:0] ts_sync_reg;
	logic       pin_req;

	// Two-flop synchronisers, idle high
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			se_sync_reg <= 2'h3;
			ts_sync_reg <= 2'h3;
		end
		else
		begin
			se_sync_reg <= {se_sync_reg[0], se_pin_n};
			ts_sync_reg <= {ts_sync_reg[0], ts_pin_n};
		end
	end

	// Pin request per selection; none and reserved ignore both pins
	always_comb
	begin
		pin_req = 1'b0;
		unique case (sel)
			slcr_pkg::SYNC_SEL_SE:   pin_req = !se_sync_reg[1];
			slcr_pkg::SYNC_SEL_TS:   pin_req = !ts_sync_reg[1];
			slcr_pkg::SYNC_SEL_NONE: pin_req = 1'b0;
			slcr_pkg::SYNC_SEL_RSVD: pin_req = 1'b0;
		endcase
	end

	// Software request always joins the pin request
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sync_request <= 1'b0;
		else
			sync_request <= pin_req || !sw_req_n;
	end

endmodule

// ---- hw/slcr_regs.sv ----
// Serial link configuration register bank with multiframe counter and sync source logic.
// Assumes an external mode table supplies encoding, E, F and lane count for the mode.
// How it works
// - Stored multiframe length plus one counts frames
// - Multiframe length resets to 31, thirty-two frames
// - Block-coded modes use 256*E/F as length
// - Writing zero to sync bit requests synchronization
// - Software request honoured under every sync selection
// - Low selected pin holds request; select 2 frees
// - Sync select: 0 single pin, 1 pair, 2 none
// - Normal mapping drives lanes 0 to L-1
// - Upper mapping drives lanes 4 to 4+L-1
// - Format bit: 0 offset binary, 1 two's complement
// - Scrambler bit switches 8B/10B scrambling, resets on
// - Block-coded modes always scramble, ignore bit
// - Disabled link holds logic, counter reset, serializers down
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module slcr_regs #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// AXI4-Lite write channels
	input  wire logic [ADDR_W-1:0]    s_awaddr,
	input  wire logic                 s_awvalid,
	output logic                      s_awready,
	input  wire logic [31:0]          s_wdata,
	input  wire logic [3:0]           s_wstrb,
	input  wire logic                 s_wvalid,
	output logic                      s_wready,
	output logic [1:0]                s_bresp,
	output logic                      s_bvalid,
	input  wire logic                 s_bready,
	// AXI4-Lite read channels
	input  wire logic [ADDR_W-1:0]    s_araddr,
	input  wire logic                 s_arvalid,
	output logic                      s_arready,
	output logic [31:0]               s_rdata,
	output logic [1:0]                s_rresp,
	output logic                      s_rvalid,
	input  wire logic                 s_rready,
	// Mode table answers for the selected output mode
	input  wire logic                 mode_is_64b66b,
	input  wire logic [3:0]           mode_e,
	input  wire logic [4:0]           mode_f,
	input  wire logic [3:0]           mode_lanes,
	// Sync pins, active low
	input  wire logic                 single_ended_sync_input_n,
	input  wire logic                 timestamp_differential_input_n,
	// Link logic frame strobe
	input  wire logic                 frame_tick,
	// Configuration and status toward the link
	output slcr_pkg::slcr_link_cfg_t  link_cfg,
	output logic                      sync_request,
	output logic                      multiframe_boundary,
	output logic [15:0]               frame_index
);

	localparam int LANES = slcr_pkg::LANE_COUNT;

	if (LANES < slcr_pkg::UPPER_LANE_BASE * 2)
		$error("upper lane mapping needs at least eight lanes");

	slcr_pkg::slcr_wr_t       wr;
	logic [9:0]               rd_idx;
	logic [7:0]               rd_word;
	logic [7:0]               enable_reg;
	logic [7:0]               mode_reg;
	logic [7:0]               km1_reg;
	logic [7:0]               swsync_reg;
	logic [7:0]               ctrl_reg;
	logic                     link_subsystem_enable;
	logic                     software_sync_request_n;
	logic                     upper_lane_mapping;
	logic                     sample_number_format;
	logic                     scrambler_enable;
	slcr_pkg::slcr_sync_sel_t sync_sel;
	logic [15:0]              frames_next;
	logic [LANES-1:0]         lanes_next;
	logic [15:0]              frame_cnt_reg;
	logic                     mf_wrap;

	// Lane mask for L lanes, moved up to the upper group on request
	function automatic logic [LANES-1:0] lane_mask(input logic [3:0] l, input logic upper);
		logic [LANES-1:0] base;
		base = LANES'((16'h0001 << l) - 16'h0001);
		if (upper)
			return base << slcr_pkg::UPPER_LANE_BASE;
		return base;
	endfunction

	// Masked store: reserved bits never latch
	function automatic logic [7:0] masked(input logic [7:0] d, input logic [7:0] m);
		return d & m;
	endfunction

	// Bus front end
	slcr_axil_slave #(
		.ADDR_W (ADDR_W)
	) u_bus (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.s_awaddr  (s_awaddr),
		.s_awvalid (s_awvalid),
		.s_awready (s_awready),
		.s_wdata   (s_wdata),
		.s_wstrb   (s_wstrb),
		.s_wvalid  (s_wvalid),
		.s_wready  (s_wready),
		.s_bresp   (s_bresp),
		.s_bvalid  (s_bvalid),
		.s_bready  (s_bready),
		.s_araddr  (s_araddr),
		.s_arvalid (s_arvalid),
		.s_arready (s_arready),
		.s_rdata   (s_rdata),
		.s_rresp   (s_rresp),
		.s_rvalid  (s_rvalid),
		.s_rready  (s_rready),
		.wr        (wr),
		.rd_idx    (rd_idx),
		.rd_word   (rd_word)
	);

	// Link enable register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			enable_reg <= slcr_pkg::RST_ENABLE;
		else if (wr.en && wr.idx == slcr_pkg::IDX_ENABLE)
			enable_reg <= masked(wr.data, slcr_pkg::MASK_ENABLE);
	end

	// Mode select register, passed on to the mode table
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			mode_reg <= slcr_pkg::RST_MODE;
		else if (wr.en && wr.idx == slcr_pkg::IDX_MODE)
			mode_reg <= masked(wr.data, slcr_pkg::MASK_MODE);
	end

	// Multiframe length register; legality per mode is left to software
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			km1_reg <= slcr_pkg::RST_KM1;
		else if (wr.en && wr.idx == slcr_pkg::IDX_KM1)
			km1_reg <= masked(wr.data, slcr_pkg::MASK_KM1);
	end

	// Software sync request, active low, idle high
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			swsync_reg <= slcr_pkg::RST_SWSYNC;
		else if (wr.en && wr.idx == slcr_pkg::IDX_SWSYNC)
			swsync_reg <= masked(wr.data, slcr_pkg::MASK_SWSYNC);
	end

	// Link control register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl_reg <= slcr_pkg::RST_CTRL;
		else if (wr.en && wr.idx == slcr_pkg::IDX_CTRL)
			ctrl_reg <= masked(wr.data, slcr_pkg::MASK_CTRL);
	end

	// Field breakout
	assign link_subsystem_enable   = enable_reg[0];
	assign software_sync_request_n = swsync_reg[0];
	assign scrambler_enable        = ctrl_reg[slcr_pkg::CTRL_SCR_BIT];
	assign sample_number_format    = ctrl_reg[slcr_pkg::CTRL_FMT_BIT];
	assign upper_lane_mapping      = ctrl_reg[slcr_pkg::CTRL_UPPER_BIT];
	assign sync_sel = slcr_pkg::slcr_sync_sel_t'(ctrl_reg[slcr_pkg::CTRL_SEL_LSB +: 2]);

	// Read mux; stored values already have reserved bits clear
	always_comb
	begin
		unique case (rd_idx)
			slcr_pkg::IDX_ENABLE: rd_word = enable_reg;
			slcr_pkg::IDX_MODE:   rd_word = mode_reg;
			slcr_pkg::IDX_KM1:    rd_word = km1_reg;
			slcr_pkg::IDX_SWSYNC: rd_word = swsync_reg;
			slcr_pkg::IDX_CTRL:   rd_word = ctrl_reg;
			default:              rd_word = 8'h00;
		endcase
	end

	// Effective multiframe length: block coding overrides the register
	always_comb
	begin
		if (mode_is_64b66b)
			frames_next = slcr_pkg::slcr_frames_64b(mode_e, mode_f);
		else
			frames_next = {8'h00, km1_reg} + 16'h0001;
	end

	// Lane usage; more than four lanes with upper mapping is undefined
	assign lanes_next = lane_mask(mode_lanes, upper_lane_mapping);

	// Registered configuration toward the link
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			link_cfg <= '{serdes_powerdown: 1'b1, default: '0};
		else
		begin
			link_cfg.link_run         <= link_subsystem_enable;
			link_cfg.serdes_powerdown <= !link_subsystem_enable;
			link_cfg.mode             <= mode_reg[5:0];
			link_cfg.frames           <= frames_next;
			link_cfg.lanes            <= link_subsystem_enable ? lanes_next : '0;
			link_cfg.twos_complement  <= sample_number_format;
			// Block coding cannot run unscrambled, so the bit is ignored there
			link_cfg.scramble         <= mode_is_64b66b || scrambler_enable;
		end
	end

	// Sync request source
	slcr_sync_select u_sync (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.se_pin_n     (single_ended_sync_input_n),
		.ts_pin_n     (timestamp_differential_input_n),
		.sel          (sync_sel),
		.sw_req_n     (software_sync_request_n),
		.sync_request (sync_request)
	);

	// Multiframe frame counter, wrapping at the effective length
	assign mf_wrap = frame_tick && ((frame_cnt_reg + 16'h0001) >= link_cfg.frames);

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !link_subsystem_enable)
			frame_cnt_reg <= 16'h0000;
		else if (mf_wrap)
			frame_cnt_reg <= 16'h0000;
		else if (frame_tick)
			frame_cnt_reg <= frame_cnt_reg + 16'h0001;
	end

	// Boundary pulse one cycle after the last frame of a multiframe
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !link_subsystem_enable)
			multiframe_boundary <= 1'b0;
		else
			multiframe_boundary <= mf_wrap;
	end

	assign frame_index = frame_cnt_reg;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_km1_frames;
		(wr.en && wr.idx == slcr_pkg::IDX_KM1 && !mode_is_64b66b) ##1 !mode_is_64b66b
			|=> link_cfg.frames == {8'h00, $past(wr.data, 2)} + 16'h0001;
	endproperty
	a_km1_frames: assert property (p_km1_frames)
		else $error("frame count is not stored length plus one");

	property p_km1_reset;
		$past(!aresetn) |-> km1_reg == 8'h1F;
	endproperty
	a_km1_reset: assert property (p_km1_reset)
		else $error("length register not 31 after reset");

	property p_frames_64b;
		aresetn && mode_is_64b66b && $stable(mode_e) && $stable(mode_f)
			|=> link_cfg.frames == slcr_pkg::slcr_frames_64b($past(mode_e), $past(mode_f));
	endproperty
	a_frames_64b: assert property (p_frames_64b)
		else $error("block-coded length is not 256*E/F");

	property p_sw_sync;
		(wr.en && wr.idx == slcr_pkg::IDX_SWSYNC && !wr.data[0]) |-> ##2 sync_request;
	endproperty
	a_sw_sync: assert property (p_sw_sync)
		else $error("software sync write raised no request");

	property p_sw_any_sel;
		!software_sync_request_n |=> sync_request;
	endproperty
	a_sw_any_sel: assert property (p_sw_any_sel)
		else $error("software request lost under a sync selection");

	property p_pin_hold;
		(sync_sel == slcr_pkg::SYNC_SEL_SE && !single_ended_sync_input_n)[*4] |-> sync_request;
	endproperty
	a_pin_hold: assert property (p_pin_hold)
		else $error("low sync pin did not hold the request");

	property p_no_pin;
		(sync_sel[1] && software_sync_request_n)[*2] |-> !sync_request;
	endproperty
	a_no_pin: assert property (p_no_pin)
		else $error("pin request leaked with no pin selected");

	property p_ts_pin;
		(sync_sel == slcr_pkg::SYNC_SEL_TS && !timestamp_differential_input_n)[*4]
			|-> sync_request;
	endproperty
	a_ts_pin: assert property (p_ts_pin)
		else $error("timestamp pair request not seen");

	property p_lanes_low;
		(aresetn && link_subsystem_enable && !upper_lane_mapping) ##1 $stable(mode_lanes)
			|-> link_cfg.lanes == lane_mask(mode_lanes, 1'b0);
	endproperty
	a_lanes_low: assert property (p_lanes_low)
		else $error("normal mapping lane set wrong");

	property p_lanes_up;
		link_subsystem_enable && upper_lane_mapping |=> link_cfg.lanes[3:0] == 4'h0;
	endproperty
	a_lanes_up: assert property (p_lanes_up)
		else $error("upper mapping used a low lane");

	property p_format;
		aresetn |=> link_cfg.twos_complement == $past(sample_number_format);
	endproperty
	a_format: assert property (p_format)
		else $error("sample format does not follow the bit");

	property p_scr_8b;
		aresetn && !mode_is_64b66b |=> link_cfg.scramble == $past(scrambler_enable);
	endproperty
	a_scr_8b: assert property (p_scr_8b)
		else $error("8B/10B scrambling does not follow the bit");

	property p_scr_64b;
		aresetn && mode_is_64b66b |=> link_cfg.scramble;
	endproperty
	a_scr_64b: assert property (p_scr_64b)
		else $error("block-coded mode left unscrambled");

	property p_disabled;
		!link_subsystem_enable |=> frame_cnt_reg == 16'h0000 && !multiframe_boundary
			&& link_cfg.serdes_powerdown && !link_cfg.link_run;
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("disabled link not held in reset");

	property p_rsvd_sel;
		(sync_sel == slcr_pkg::SYNC_SEL_RSVD && software_sync_request_n)[*2] |-> !sync_request;
	endproperty
	a_rsvd_sel: assert property (p_rsvd_sel)
		else $error("reserved selection let a pin through");

	// Main scenarios
	c_sw_sync:  cover property (!software_sync_request_n ##1 sync_request);
	c_mf_wrap:  cover property (multiframe_boundary);
	c_upper:    cover property (link_subsystem_enable && upper_lane_mapping ##1 link_cfg.lanes[4]);
	c_mode_64b: cover property (mode_is_64b66b && link_cfg.scramble && !scrambler_enable);

endmodule

// ---- dv/slcr_rx_model.sv ----
// Far-end receiver model: active low sync pins and the frame strobe.
// Assumes the bench commands it in the aclk domain.
`timescale 1ns/1ps
module slcr_rx_model (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Bench commands
	input  wire logic se_req,
	input  wire logic ts_req,
	// Toward the device
	output logic      se_pin_n,
	output logic      ts_pin_n,
	output logic      frame_tick
);
	// Pins follow commands; strobe every other cycle, quiet in reset
	always_ff @(posedge aclk)
	begin
		se_pin_n   <= !se_req;
		ts_pin_n   <= !ts_req;
		frame_tick <= aresetn && !frame_tick;
	end
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for the link config registers over AXI4-Lite.
// Assumes the receiver model drives the sync pins and frame strobe.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin mismatches++; \
	$display("ERROR %s exp %0h got %0h", n, e, s); end end
module tb_top;
	logic                     aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic                     awready, wready, bvalid, arready, rvalid;
	logic [11:0]              awaddr, araddr;
	logic [31:0]              wdata, rdata, rv;
	logic [1:0]               bresp, rresp, resp;
	logic                     is64, se_req, ts_req, se_n, ts_n, tick, sync_req, bnd;
	logic [3:0]               e, lanes_l, strb;
	logic [4:0]               f;
	logic [15:0]              fidx;
	logic [7:0]               km1, ctl, md;
	slcr_pkg::slcr_link_cfg_t cfg;
	int                       mismatches, checked, cnt;
	logic [31:0]              rst_val [5] = '{32'h01, 32'h00, 32'h1F, 32'h01, 32'h03};

	slcr_regs dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr), .s_awvalid(awvalid),
		.s_awready(awready), .s_wdata(wdata), .s_wstrb(strb), .s_wvalid(wvalid),
		.s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
		.s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
		.s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .mode_is_64b66b(is64),
		.mode_e(e), .mode_f(f), .mode_lanes(lanes_l), .single_ended_sync_input_n(se_n),
		.timestamp_differential_input_n(ts_n), .frame_tick(tick), .link_cfg(cfg),
		.sync_request(sync_req), .multiframe_boundary(bnd), .frame_index(fidx));

	slcr_rx_model far (.aclk(aclk), .aresetn(aresetn), .se_req(se_req), .ts_req(ts_req),
		.se_pin_n(se_n), .ts_pin_n(ts_n), .frame_tick(tick));

	// Clock
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// Write: address and data offered together, each dropped when taken
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!(ad && wd))
		begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1)
			begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready === 1'b1)
			begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		resp = bresp;
		repeat (3) @(posedge aclk); // Lets the change reach link_cfg
	endtask

	// Read: ready held until the answer is sampled
	task automatic rd(input logic [11:0] a);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		rv = rdata;
		resp = rresp;
	endtask

	// Expected frames per multiframe
	function automatic logic [15:0] exp_frames(logic [7:0] k, logic s64, logic [3:0] ee,
		logic [4:0] ff);
		return s64 ? 16'(256 * int'(ee) / int'(ff)) : 16'(k) + 16'h0001;
	endfunction

	task automatic wrap_up;
		if (mismatches == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Watchdog, far beyond the expected run length
	initial
	begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		wrap_up();
	end

	// Main sequence
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, se_req, ts_req, is64} = '0;
		{awaddr, araddr, wdata} = '0;
		e = 4'h1;
		f = 5'h1;
		lanes_l = 4'h1;
		strb = 4'hF;
		mismatches = 0;
		checked = 0;
		void'($urandom(32'h173B));
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		`CHK("reset frames", 16'h0020, cfg.frames)
		for (int i = 0; i < 5; i++)
		begin
			rd(12'h800 + 12'(4 * i));
			`CHK("reset value", rst_val[i], rv)
		end
		rd(12'h814);
		`CHK("unmapped resp", slcr_pkg::RESP_SLVERR, resp)
		wr(12'h814, 8'h00);
		`CHK("unmapped write resp", slcr_pkg::RESP_SLVERR, resp)
		wr(12'h800, 8'h00);
		`CHK("disabled", 10'h100, {cfg.link_run, cfg.serdes_powerdown, cfg.lanes})
		// Sync sources; pins settle through synchronisers
		se_req <= 1'b1;
		repeat (5) @(posedge aclk);
		`CHK("sync pin", 1'b1, sync_req)
		wr(12'h810, 8'h0B);
		`CHK("sync none", 1'b0, sync_req)
		se_req <= 1'b0;
		ts_req <= 1'b1;
		wr(12'h810, 8'h07);
		`CHK("sync pair", 1'b1, sync_req)
		wr(12'h810, 8'h0F);
		`CHK("sync rsvd", 1'b0, sync_req)
		wr(12'h80C, 8'h00);
		`CHK("sync soft", 1'b1, sync_req)
		wr(12'h80C, 8'h01);
		ts_req <= 1'b0;
		// Random legal configurations, changed only while disabled
		for (int i = 0; i < 6; i++)
		begin
			km1 = 8'($urandom_range(1, 63));
			md = 8'($urandom_range(0, 63));
			ctl = {3'h0, 1'($urandom), 2'h2, 2'($urandom)};
			is64 <= i[0];
			e <= 4'($urandom_range(1, 8));
			f <= 5'($urandom_range(1, 8));
			lanes_l <= 4'($urandom_range(1, 4));
			wr(12'h804, md);
			`CHK("write resp", slcr_pkg::RESP_OKAY, resp)
			wr(12'h808, km1);
			wr(12'h810, ctl);
			// Byte lane 0 off: the length must keep its value
			strb <= 4'hE;
			wr(12'h808, ~km1);
			strb <= 4'hF;
			rd(12'h808);
			`CHK("length readback", {24'h000000, km1}, rv)
			wr(12'h800, 8'h01);
			`CHK("mode", md[5:0], cfg.mode)
			`CHK("frames", exp_frames(km1, is64, e, f), cfg.frames)
			`CHK("lanes", 8'(((1 << lanes_l) - 1) << (ctl[4] ? 4 : 0)), cfg.lanes)
			`CHK("scramble", is64 | ctl[0], cfg.scramble)
			`CHK("format", ctl[1], cfg.twos_complement)
			// Counter period: a strobe every other cycle, K strobes per multiframe
			if (!is64)
			begin
				do @(posedge aclk); while (bnd !== 1'b1);
				`CHK("index at boundary", 16'h0000, fidx)
				cnt = 0;
				do
				begin
					@(posedge aclk);
					cnt++;
				end
				while (bnd !== 1'b1);
				`CHK("multiframe period", 2 * (int'(km1) + 1), cnt)
			end
			wr(12'h800, 8'h00);
		end
		wrap_up();
	end
endmodule
